// ---- hdl/sar_adc_sequencer.sv ----
// sequencer for a 10-bit successive-approximation converter
// Summary of operation
// - ten-bit successive approximation; result lands in high and low bytes at completion.
// - channel select routes one analog input to the sample-and-hold.
// - positive reference supply, fixed or pin; negative reference ground or pin.
// - nonzero acquisition setting samples 2 to 20 bit periods, then converts.
// - acquisition setting 000 stops sampling at go and converts after the instruction-cycle wait, with no acquisition time.
// - acquisition time field resets to 000, manual acquisition.
// - conversion end clears go, sets flag, resumes sampling selected channel.
// - no status marks acquisition-to-conversion change; go stays set throughout.
// - clock select picks system clock /2../64 or internal oscillator.
// - a full conversion takes eleven bit periods.
// - flag set on every completion; interrupt only when enabled.
// - flag never clears itself; software clears it.
// - completion interrupt during sleep wakes the device.
// - format bit selects left or right justification of the result pair.
// - converter works only while its enable bit is one.
// - conversion begins only after the next instruction cycle following go.
// - acquisition code 010 inserts four bit periods of acquisition.
// - port reads zero on analog pins; conversion ignores pin settings.
// - two bit periods wait after completion or go-clear abort before next acquisition.
// - clearing go mid-conversion writes partial result, low bits copy last bit.
// - sleep without internal oscillator aborts and powers down, enable stays.
// - compare unit trigger sets go in hardware.
`timescale 1ns/1ps

module sar_adc_sequencer #(
  parameter int CHANNELS = 16,
  parameter int PINS     = 8
) (
  input  wire logic                i_sys_clk,
  input  wire logic                i_resetn,
  input  wire logic                i_converter_enable,
  input  wire logic                i_go_set,
  input  wire logic                i_go_clear,
  input  wire logic                i_special_trigger,
  input  wire logic                i_flag_clear,
  input  wire logic                i_conversion_irq_enable,
  input  wire logic                i_sleep,
  input  wire logic                i_osc_tick,
  input  wire logic                i_comparator,
  input  wire logic                i_config_write,
  input  wire logic [2:0]          i_acquisition_time_select,
  input  wire logic [2:0]          i_conversion_clock_select,
  input  wire logic                i_result_justify_select,
  input  wire logic [3:0]          i_input_channel_select,
  input  wire logic [1:0]          i_positive_reference_select,
  input  wire logic                i_negative_reference_select,
  input  wire logic [PINS-1:0]     i_pin_level,
  input  wire logic [PINS-1:0]     i_analog_pin_select,
  output logic                     o_go_busy,
  output logic                     o_conversion_complete_flag,
  output logic                     o_irq,
  output logic                     o_wake,
  output logic                     o_converter_active,
  output logic                     o_sample_connected,
  output logic [CHANNELS-1:0]      o_channel_route,
  output logic [2:0]               o_positive_reference_route,
  output logic                     o_negative_reference_external,
  output logic [9:0]               o_sar_trial,
  output logic [7:0]               o_result_high_byte,
  output logic [7:0]               o_result_low_byte,
  output logic [PINS-1:0]          o_port_read
);

  if (CHANNELS < 1 || CHANNELS > 16) begin : g_bad_channels
    $error("CHANNELS must be 1 to 16");
  end
  if (PINS < 1) begin : g_bad_pins
    $error("PINS must be at least 1");
  end

  typedef struct packed {
    sar_adc_pkg::seq_state_t st;
    logic                    go;
    logic                    flag;
    logic                    sleep_off;
    logic                    sample;
    logic [9:0]              sar;
    logic [4:0]              cnt;
    logic [5:0]              div;
    logic [2:0]              acq_sel;
    logic [2:0]              clk_sel;
    logic                    justify;
    logic [7:0]              res_high;
    logic [7:0]              res_low;
    logic [PINS-1:0]         port_rd;
  } seq_t;

  seq_t r;
  seq_t next_r;
  logic frc;
  logic bit_conversion_period;
  logic finish;
  logic result_load;

  // left: high=r[9:2], low={r[1:0],0}; right: high={0,r[9:8]}, low=r[7:0]
  function automatic logic [15:0] justify(input logic [9:0] v, input logic left);
    if (left) begin
      justify = {v, {sar_adc_pkg::PAD_W{1'b0}}};
    end else begin
      justify = {{sar_adc_pkg::PAD_W{1'b0}}, v};
    end
  endfunction

  // bits not yet resolved copy the last resolved bit
  function automatic logic [9:0] partial(input logic [9:0] v, input logic [4:0] done_bits);
    logic [9:0] res;
    logic       last;
    res  = v;
    last = (done_bits == 5'h00) ? 1'b0 : v[4'(10 - int'(done_bits))];
    for (int i = 0; i < 10; i++) begin
      if (i < 10 - int'(done_bits)) begin
        res[i] = last;
      end
    end
    partial = res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bit-period timebase

  assign frc    = r.clk_sel[1:0] == sar_adc_pkg::CLK_FRC_LOW;
  // divider runs free, so the first period after go may be short
  // a count left above a faster divider's end closes the period at once instead of wrapping
  assign bit_conversion_period    = frc ? i_osc_tick : (r.div >= sar_adc_pkg::div_last(r.clk_sel));
  assign finish = r.st == sar_adc_pkg::S_CONV && bit_conversion_period && r.cnt == sar_adc_pkg::CONV_TADS - 5'h01;
  assign result_load = finish || (i_go_clear && r.go && r.st == sar_adc_pkg::S_CONV);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    next_r         = r;
    next_r.div     = (frc || bit_conversion_period) ? 6'h00 : r.div + 6'h01;
    next_r.port_rd = i_pin_level & ~i_analog_pin_select;
    if (i_config_write) begin
      next_r.acq_sel = i_acquisition_time_select;
      next_r.clk_sel = i_conversion_clock_select;
      next_r.justify = i_result_justify_select;
    end
    if (i_flag_clear) begin
      next_r.flag = 1'b0;
    end
    if (!i_sleep) begin
      next_r.sleep_off = 1'b0;
    end
    if (!i_converter_enable || r.sleep_off) begin
      next_r.st  = sar_adc_pkg::S_IDLE;
      next_r.go  = 1'b0;
      next_r.cnt = 5'h00;
    end else if (i_sleep && !frc) begin
      // clock is about to stop: drop the conversion, keep the enable
      next_r.sleep_off = 1'b1;
      next_r.st        = sar_adc_pkg::S_IDLE;
      next_r.go        = 1'b0;
      next_r.cnt       = 5'h00;
    end else if (i_go_clear && r.go) begin
      if (r.st == sar_adc_pkg::S_CONV) begin
        {next_r.res_high, next_r.res_low} = justify(partial(r.sar, r.cnt), r.justify);
      end
      next_r.go  = 1'b0;
      next_r.st  = sar_adc_pkg::S_DISCH;
      next_r.cnt = 5'h00;
    end else begin
      case (r.st)
        sar_adc_pkg::S_IDLE: begin
          if (r.go) begin
            next_r.st  = sar_adc_pkg::S_WAIT;
            next_r.cnt = 5'h00;
          end
        end
        sar_adc_pkg::S_WAIT: begin
          // one instruction cycle of slack so a sleep can follow go
          if (r.cnt == 5'(sar_adc_pkg::INSTR_CLOCKS - 3'h1)) begin
            next_r.cnt = 5'h00;
            next_r.sar = sar_adc_pkg::SAR_FIRST;
            if (r.acq_sel == sar_adc_pkg::ACQ_MANUAL) begin
              next_r.st = sar_adc_pkg::S_CONV;
            end else begin
              next_r.st = sar_adc_pkg::S_ACQ;
            end
          end else begin
            next_r.cnt = r.cnt + 5'h01;
          end
        end
        sar_adc_pkg::S_ACQ: begin
          if (bit_conversion_period) begin
            if (r.cnt == sar_adc_pkg::acq_tads(r.acq_sel) - 5'h01) begin
              next_r.st  = sar_adc_pkg::S_CONV;
              next_r.cnt = 5'h00;
            end else begin
              next_r.cnt = r.cnt + 5'h01;
            end
          end
        end
        sar_adc_pkg::S_CONV: begin
          if (finish) begin
            {next_r.res_high, next_r.res_low} = justify(r.sar, r.justify);
            next_r.flag = 1'b1;
            next_r.go   = 1'b0;
            next_r.st   = sar_adc_pkg::S_DISCH;
            next_r.cnt  = 5'h00;
            if (i_sleep && !i_conversion_irq_enable) begin
              next_r.sleep_off = 1'b1;
            end
          end else if (bit_conversion_period) begin
            next_r.sar[4'(9 - int'(r.cnt))] = i_comparator;
            if (r.cnt < 5'h09) begin
              next_r.sar[4'(8 - int'(r.cnt))] = 1'b1;
            end
            next_r.cnt = r.cnt + 5'h01;
          end
        end
        sar_adc_pkg::S_DISCH: begin
          if (bit_conversion_period) begin
            if (r.cnt == sar_adc_pkg::GAP_TADS - 5'h01) begin
              next_r.st  = r.go ? sar_adc_pkg::S_WAIT : sar_adc_pkg::S_IDLE;
              next_r.cnt = 5'h00;
            end else begin
              next_r.cnt = r.cnt + 5'h01;
            end
          end
        end
        default: begin
          next_r.st = sar_adc_pkg::S_IDLE;
        end
      endcase
      // a running cycle already holds go; new starts only when quiet
      if ((i_go_set || i_special_trigger) && !finish &&
          (r.st == sar_adc_pkg::S_IDLE || r.st == sar_adc_pkg::S_DISCH)) begin
        next_r.go = 1'b1;
      end
    end
    next_r.sample = i_converter_enable && !next_r.sleep_off &&
                    (next_r.st == sar_adc_pkg::S_IDLE || next_r.st == sar_adc_pkg::S_ACQ ||
                     (next_r.st == sar_adc_pkg::S_WAIT && next_r.acq_sel != sar_adc_pkg::ACQ_MANUAL));
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r         <= '0;
      r.st      <= sar_adc_pkg::S_IDLE;
      r.acq_sel <= sar_adc_pkg::ACQ_RESET;
      r.clk_sel <= sar_adc_pkg::CLK_RESET;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_go_busy                    = r.go;
  assign o_conversion_complete_flag   = r.flag;
  assign o_irq                        = r.flag && i_conversion_irq_enable;
  assign o_wake                       = o_irq && i_sleep;
  assign o_converter_active           = i_converter_enable && !r.sleep_off;
  assign o_sample_connected           = r.sample;
  assign o_channel_route              = r.sample ? CHANNELS'(1) << i_input_channel_select : '0;
  assign o_positive_reference_route   = {i_positive_reference_select == sar_adc_pkg::PREF_FIXED,
                                         i_positive_reference_select == sar_adc_pkg::PREF_EXT,
                                         i_positive_reference_select == sar_adc_pkg::PREF_SUPPLY ||
                                         i_positive_reference_select == 2'h3};
  assign o_negative_reference_external = i_negative_reference_select;
  assign o_sar_trial                  = r.sar;
  assign o_result_high_byte           = r.res_high;
  assign o_result_low_byte            = r.res_low;
  assign o_port_read                  = r.port_rd;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  a_flag_sticky: assert property (r.flag && !i_flag_clear |=> r.flag)
    else $error("completion flag dropped without clear");
  a_flag_set_wins: assert property (finish |=> r.flag)
    else $error("completion did not set flag");
  a_done_clears_go: assert property (finish |=> !r.go && r.st == sar_adc_pkg::S_DISCH)
    else $error("go still set after completion");
  a_manual_no_sample: assert property (r.st == sar_adc_pkg::S_WAIT && r.acq_sel == sar_adc_pkg::ACQ_MANUAL
                                       |-> !o_sample_connected)
    else $error("sampling during manual start");
  a_go_busy_phases: assert property (r.st inside {sar_adc_pkg::S_WAIT, sar_adc_pkg::S_ACQ,
                                     sar_adc_pkg::S_CONV} |-> o_go_busy)
    else $error("go low during acquisition or conversion");
  a_right_pad_zero: assert property (finish && !r.justify |=> o_result_high_byte[7:2] == 6'h00)
    else $error("right-justified pad not zero");
  a_left_pad_zero: assert property (finish && r.justify |=> o_result_low_byte[5:0] == 6'h00)
    else $error("left-justified pad not zero");
  a_wake_enable: assert property (o_wake |-> i_conversion_irq_enable && r.flag)
    else $error("wake without enabled flag");
  a_disabled_idle: assert property (!i_converter_enable |=> r.st == sar_adc_pkg::S_IDLE && !r.go)
    else $error("converter ran while disabled");
  a_instr_delay: assert property (r.st == sar_adc_pkg::S_IDLE && r.go && i_converter_enable && !i_sleep
                                  && !i_go_clear && !r.sleep_off
                                  |=> (r.st == sar_adc_pkg::S_WAIT) [*4])
    else $error("conversion began before an instruction cycle");
  a_port_analog_zero: assert property ((o_port_read & $past(i_analog_pin_select)) == '0)
    else $error("analog pin read nonzero");
  a_sleep_abort: assert property (i_sleep && !frc && i_converter_enable && !r.sleep_off
                                  |=> !r.go && r.sleep_off && !o_converter_active)
    else $error("sleep did not abort conversion");

  // completion, abort and power-down side effects, and the sample switch in the gap, conversion and acquisition states
  a_flag_needs_done: assert property ($rose(r.flag) |-> $past(finish))
    else $error("flag rose without a completion");
  a_result_only_end: assert property ($changed({r.res_high, r.res_low})
                                      |-> $past(result_load))
    else $error("result changed outside completion or abort");
  a_abort_to_gap: assert property (i_go_clear && r.go && i_converter_enable && !r.sleep_off
                                   && !(i_sleep && !frc) |=> !r.go && r.st == sar_adc_pkg::S_DISCH)
    else $error("abort did not stop the conversion");
  a_abort_keeps_flag: assert property (i_go_clear && r.go && r.st == sar_adc_pkg::S_CONV && !i_flag_clear
                                       |=> r.flag == $past(r.flag))
    else $error("abort changed the completion flag");
  a_sleep_off_idle: assert property (r.sleep_off |=> r.st == sar_adc_pkg::S_IDLE && !r.go)
    else $error("powered-down converter kept running");
  a_gap_no_sample: assert property (r.st == sar_adc_pkg::S_DISCH |-> !o_sample_connected)
    else $error("sampling during the discharge gap");
  a_conv_holds: assert property (r.st == sar_adc_pkg::S_CONV |-> !o_sample_connected)
    else $error("sample switch closed while converting");
  a_acq_samples: assert property (r.st == sar_adc_pkg::S_ACQ |-> o_sample_connected)
    else $error("acquisition without sampling");

  // outputs seen by the analog side and the interrupt logic
  a_route_onehot: assert property (o_sample_connected && int'(i_input_channel_select) < CHANNELS
                                   |-> $onehot(o_channel_route))
    else $error("sampling with no single channel routed");
  a_route_idle: assert property (!o_sample_connected |-> o_channel_route == '0)
    else $error("channel routed while the switch is open");
  a_irq_masked: assert property (!i_conversion_irq_enable |-> !o_irq)
    else $error("interrupt raised while disabled");

  c_completion: cover property (finish);
  c_abort_partial: cover property (r.st == sar_adc_pkg::S_CONV && i_go_clear && r.go);
  c_acq_four: cover property (r.st == sar_adc_pkg::S_ACQ && r.acq_sel == 3'h2 ##[1:400] finish);
  c_sleep_abort: cover property (r.go && i_sleep && !frc);
  c_gap_queue: cover property (r.st == sar_adc_pkg::S_DISCH && r.go);

endmodule

// ---- hdl/sar_adc_pkg.sv ----
// constants, state encoding and decode helpers for the sar converter sequencer
package sar_adc_pkg;

  localparam int          RESULT_W      = 10;
  localparam logic [2:0]  INSTR_CLOCKS  = 3'h4;
  localparam logic [4:0]  CONV_TADS     = 5'h0B;
  localparam logic [4:0]  GAP_TADS      = 5'h02;
  localparam logic [2:0]  ACQ_MANUAL    = 3'h0;
  localparam logic [2:0]  ACQ_RESET     = 3'h0;
  localparam logic [2:0]  CLK_RESET     = 3'h0;
  localparam logic [1:0]  CLK_FRC_LOW   = 2'h3;
  localparam logic [9:0]  SAR_FIRST     = 10'h200;
  localparam logic [1:0]  PREF_SUPPLY   = 2'h0;
  localparam logic [1:0]  PREF_EXT      = 2'h1;
  localparam logic [1:0]  PREF_FIXED    = 2'h2;
  localparam int          PREF_W        = 3;
  localparam int          PAD_W         = 6;

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_WAIT  = 5'h02,
    S_ACQ   = 5'h04,
    S_CONV  = 5'h08,
    S_DISCH = 5'h10
  } seq_state_t;

  // acquisition length in bit periods per select code
  function automatic logic [4:0] acq_tads(input logic [2:0] sel);
    case (sel)
      3'h1:    acq_tads = 5'h02;
      3'h2:    acq_tads = 5'h04;
      3'h3:    acq_tads = 5'h06;
      3'h4:    acq_tads = 5'h08;
      3'h5:    acq_tads = 5'h0C;
      3'h6:    acq_tads = 5'h10;
      3'h7:    acq_tads = 5'h14;
      default: acq_tads = 5'h00;
    endcase
  endfunction

  // last divider count: codes 000,100,001,101,010,110 give /2 .. /64
  function automatic logic [5:0] div_last(input logic [2:0] sel);
    logic [2:0] idx;
    idx      = {sel[1:0], sel[2]};
    div_last = 6'((7'h02 << idx) - 7'h01);
  endfunction

endpackage

// ---- tb/analog_front_end.sv ----
// behavioural analog front end: per-channel levels, hold capacitor and comparator
`timescale 1ns/1ps

module analog_front_end (
  input  wire logic              i_sys_clk,
  input  wire logic [15:0]       i_channel_route,
  input  wire logic              i_sample_connected,
  input  wire logic [15:0][9:0]  i_levels,
  input  wire logic [9:0]        i_sar_trial,
  output logic                   o_comparator
);
  logic [9:0] picked;
  logic [9:0] held;

  always_comb begin
    picked = 10'h000;
    for (int k = 0; k < 16; k++) begin
      if (i_channel_route[k]) picked = i_levels[k];
    end
  end

  // the hold capacitor keeps the last level once the switch opens
  always_ff @(posedge i_sys_clk) begin
    if (i_sample_connected) held <= picked;
  end

  assign o_comparator = (held >= i_sar_trial);
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the sar converter sequencer
`timescale 1ns/1ps

module tb_top;
  logic              sys_clk, resetn, enable, go_set, go_clear, trig, flag_clear, irq_en, sleep;
  logic              osc_tick, cfg_wr, justify, neg_ref, comp;
  logic [2:0]        acq_sel, clk_sel, pref_route;
  logic [3:0]        chan;
  logic [1:0]        pos_ref;
  logic [7:0]        pins, ana_sel, res_hi, res_lo, port_rd;
  logic              go_busy, flag, irq, wake, active, sample, neg_ext;
  logic [15:0]       route;
  logic [9:0]        trial;
  logic [15:0][9:0]  levels;
  int                err_total, n_tests, cyc, n, osc_cnt;
  int                divs [8] = '{2, 4, 8, 16, 32, 64, 4, 4};
  logic [2:0]        codes [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};

  sar_adc_sequencer #(.CHANNELS(16), .PINS(8)) dut (
    .i_sys_clk(sys_clk), .i_resetn(resetn), .i_converter_enable(enable), .i_go_set(go_set),
    .i_go_clear(go_clear), .i_special_trigger(trig), .i_flag_clear(flag_clear),
    .i_conversion_irq_enable(irq_en), .i_sleep(sleep), .i_osc_tick(osc_tick), .i_comparator(comp),
    .i_config_write(cfg_wr), .i_acquisition_time_select(acq_sel), .i_conversion_clock_select(clk_sel),
    .i_result_justify_select(justify), .i_input_channel_select(chan), .i_positive_reference_select(pos_ref),
    .i_negative_reference_select(neg_ref), .i_pin_level(pins), .i_analog_pin_select(ana_sel),
    .o_go_busy(go_busy), .o_conversion_complete_flag(flag), .o_irq(irq), .o_wake(wake),
    .o_converter_active(active), .o_sample_connected(sample), .o_channel_route(route),
    .o_positive_reference_route(pref_route), .o_negative_reference_external(neg_ext), .o_sar_trial(trial),
    .o_result_high_byte(res_hi), .o_result_low_byte(res_lo), .o_port_read(port_rd));

  analog_front_end afe (.i_sys_clk(sys_clk), .i_channel_route(route), .i_sample_connected(sample),
    .i_levels(levels), .i_sar_trial(trial), .o_comparator(comp));

  always #50 sys_clk = ~sys_clk;

  // internal oscillator stand-in: one bit period every four system clocks
  always @(negedge sys_clk) begin
    osc_cnt = (osc_cnt + 1) % 4;
    osc_tick = (osc_cnt == 0);
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  task automatic pulse_clear(input logic flag_not_go);
    if (flag_not_go) flag_clear = 1'b1;
    else go_clear = 1'b1;
    tick(1);
    flag_clear = 1'b0;
    go_clear = 1'b0;
  endtask

  task automatic cfg(input logic [2:0] a, input logic [2:0] c, input logic j);
    acq_sel = a;
    clk_sel = c;
    justify = j;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
  endtask

  // start by software or compare trigger, then time go until it drops
  task automatic conv(input logic hw, input logic samp, input int lo, input int hi);
    if (hw) trig = 1'b1;
    else go_set = 1'b1;
    tick(1);
    trig = 1'b0;
    go_set = 1'b0;
    chk("go_after_start", 16'h0001, {15'h0000, go_busy});
    tick(3);
    n = 4;
    chk("sample_before_conv", {15'h0000, samp}, {15'h0000, sample});
    while (go_busy === 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    chk("conv_time", 16'h0001, {15'h0000, (n >= lo && n <= hi)});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0; resetn = 1'b0; enable = 1'b1; go_set = 1'b0; go_clear = 1'b0; trig = 1'b0;
    flag_clear = 1'b0; irq_en = 1'b0; sleep = 1'b0; cfg_wr = 1'b0; justify = 1'b0;
    neg_ref = 1'b0; acq_sel = 3'h0; clk_sel = 3'h0; chan = 4'h5; pos_ref = 2'h0; pins = 8'hFF;
    ana_sel = 8'h0F; levels = '0; err_total = 0; n_tests = 0;
    levels[5] = 10'h2C6;
    tick(6);
    resetn = 1'b1;
    tick(2);
    chk("go_reset", 16'h0000, {15'h0000, go_busy});
    chk("result_reset", 16'h0000, {res_hi, res_lo});
    chk("route_ch5", 16'h0020, route);
    chk("port_read", 16'h00F0, {8'h00, port_rd});
    for (int p = 0; p < 3; p++) begin
      pos_ref = 2'(p);
      tick(1);
      chk("pos_ref_route", 16'(3'h1 << p), {13'h0000, pref_route});
    end
    pos_ref = 2'h3;
    tick(1);
    chk("pos_ref_other", 16'h0001, {13'h0000, pref_route});
    chk("neg_ref_gnd", 16'h0000, {15'h0000, neg_ext});
    neg_ref = 1'b1;
    tick(1);
    chk("neg_ref_ext", 16'h0001, {15'h0000, neg_ext});
    conv(1'b0, 1'b0, 25, 30);
    chk("result_right", 16'h02C6, {res_hi, res_lo});
    chk("flag_set", 16'h0001, {15'h0000, flag});
    chk("irq_masked", 16'h0000, {15'h0000, irq});
    chk("sample_in_gap", 16'h0000, {15'h0000, sample});
    tick(6);
    chk("sample_back", 16'h0001, {15'h0000, sample});
    tick(20);
    chk("flag_sticky", 16'h0001, {15'h0000, flag});
    irq_en = 1'b1;
    tick(1);
    chk("irq_enabled", 16'h0001, {15'h0000, irq});
    pulse_clear(1'b1);
    chk("flag_cleared", 16'h0000, {15'h0000, flag});
    cfg(3'h2, 3'h0, 1'b1);
    conv(1'b1, 1'b1, 33, 38);
    chk("result_left", 16'hB180, {res_hi, res_lo});
    chk("irq_on_done", 16'h0001, {15'h0000, irq});
    for (int i = 0; i < 8; i++) begin
      pulse_clear(1'b1);
      cfg(3'h0, codes[i], 1'b0);
      tick(140);
      conv(1'b0, 1'b0, 5 + 10 * divs[i], 6 + 12 * divs[i]);
      chk("result_clock", 16'h02C6, {res_hi, res_lo});
    end
    sleep = 1'b1;
    tick(1);
    chk("wake_on_irq", 16'h0001, {15'h0000, wake});
    sleep = 1'b0;
    pulse_clear(1'b1);
    cfg(3'h0, 3'h0, 1'b0);
    // low five bits clear: a fill from the last resolved bit differs from a full result
    levels[5] = 10'h3E0;
    tick(10);
    go_set = 1'b1;
    tick(1);
    go_set = 1'b0;
    tick(15);
    pulse_clear(1'b0);
    tick(2);
    chk("go_after_abort", 16'h0000, {15'h0000, go_busy});
    chk("partial_result", 16'h03FF, {res_hi, res_lo});
    chk("flag_kept_abort", 16'h0000, {15'h0000, flag});
    tick(10);
    go_set = 1'b1;
    tick(1);
    go_set = 1'b0;
    tick(10);
    sleep = 1'b1;
    tick(2);
    chk("go_sleep_abort", 16'h0000, {15'h0000, go_busy});
    chk("off_in_sleep", 16'h0000, {15'h0000, active});
    sleep = 1'b0;
    enable = 1'b0;
    tick(2);
    go_set = 1'b1;
    tick(1);
    go_set = 1'b0;
    tick(3);
    chk("go_disabled", 16'h0000, {15'h0000, go_busy});
    enable = 1'b1;
    tick(4);
    conv(1'b0, 1'b0, 25, 30);
    chk("result_reenable", 16'h03E0, {res_hi, res_lo});
    summarize();
  end
endmodule
